// ---- design/spif_regs.svh ----
// Register offsets, field positions and reset values of the serial port
`ifndef SPIF_REGS_SVH
`define SPIF_REGS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define SF_CTRL1 8'h00
`define SF_CTRL2 8'h04
`define SF_BAUD  8'h08
`define SF_STAT  8'h0C
`define SF_MATCH 8'h10
`define SF_DATA  8'h14

// ----------------------------------------
// Fields
// ----------------------------------------
`define SF_RFIE  7
`define SF_SE    6
`define SF_TIE   5
`define SF_MS    4
`define SF_CLOCK_POLARITY  3
`define SF_CLOCK_PHASE  2
`define SF_SELECT_OUTPUT_ENABLE  1
`define SF_LSBF  0
`define SF_MIE   7
`define SF_MFEN  4
`define SF_BDOE  3
`define SF_SWAI  1
`define SF_BIDIR 0
`define SF_RXF   7
`define SF_MF    6
`define SF_TXE   5
`define SF_MODE_FAULT_FLAG  4
`define SF_C2_MASK 8'h9B
`define SF_BR_MASK 8'h7F

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define SF_C1_RST 8'h04
`define SF_C2_RST 8'h00
`define SF_BR_RST 8'h00
`define SF_MR_RST 8'h00
`define SF_LAST_EDGE 5'h0F
`define SF_DIV_W 20

`endif

// ---- design/spif_pkg.sv ----
// Types of the serial port
package spif_pkg;

  // ----------------------------------------
  // Transfer engine modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    SF_IDLE  = 2'b00,
    SF_MXFER = 2'b01,
    SF_SXFER = 2'b10
  } spif_mode_t;

  // ----------------------------------------
  // Whole state of the port
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  c1;
    logic [7:0]  c2;
    logic [7:0]  br;
    logic [7:0]  mr;
    logic [7:0]  txb;
    logic [7:0]  rxb;
    logic        rxf;
    logic        txe;
    logic        mf;
    logic        mode_fault_flag;
    logic        arm_rx;
    logic        arm_tx;
    logic        arm_mf;
    logic        arm_fl;
    logic [7:0]  rdata;
    logic        slverr;
    spif_mode_t  mode;
    logic [7:0]  sh;
    logic        obit;
    logic        sck;
    logic        sck_prev;
    logic [4:0]  ecnt;
    logic [19:0] div;
  } spif_state_t;

endpackage

// ---- design/spif_core.sv ----
// Serial port with status flags, masks and one interrupt request
//
// Behaviour
// - General mask gates receive-full and mode-fault
// - Transmit mask gates transmit-empty only
// - Match mask gates match flag only
// - Interrupt when any flag and mask set
// - Flags set even with masks cleared
// - Mode fault aborts and clears master select
// - Fault interrupt follows mode-fault flag
// - Receive-full set when byte copied in
// - Overrun byte discarded, buffer kept
// - Transmit-empty set when shifter takes byte from buffer
// - Match set when buffer equals match value
// - Control one bit order, system enable at six
// - Control two bit assignments, gaps read zero
// - Baud register prescale and divisor fields
// - Status register flag positions
// - LSB select cleared shifts MSB first
// - Clock phase set: edge starts bit
// - Bidirectional select cleared uses two pins
// - Bidirectional output enable cleared means input
// - Stop-in-wait cleared keeps clocks running
// - Match and data registers hold eight bits
// - Master with fault enable and select output cleared, select low faults
// - Status read then control write clears fault
// - No interrupt unless system enable set
//
// Our own choices: the register offsets and the APB register port.
module spif_core
  import spif_pkg::*;
(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RESETN,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // CPU state and interrupt
  input  wire logic        CPU_WAIT,
  output logic             IRQ,
  // Serial clock pin
  input  wire logic        SCK_IN,
  output logic             SCK_OUT,
  output logic             SCK_OE,
  // Master-out data pin
  input  wire logic        MOSI_IN,
  output logic             MOSI_OUT,
  output logic             MOSI_OE,
  // Master-in data pin
  input  wire logic        MISO_IN,
  output logic             MISO_OUT,
  output logic             MISO_OE,
  // Slave select pin
  input  wire logic        SS_N_IN,
  output logic             SS_N_OUT,
  output logic             SS_N_OE
);

`include "spif_regs.svh"

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // bit order
  function automatic logic pick_bit(logic [7:0] v, logic lsb);
    return lsb ? v[0] : v[7];
  endfunction

  function automatic logic [7:0] shift_in(logic [7:0] v, logic b, logic lsb);
    return lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // half period is (prescale+1) * 2^divisor
  function automatic logic [19:0] half_period(logic [7:0] br);
    logic [19:0] p;
    p = {17'h0_0000, br[6:4]} + 20'h0_0001;
    return p << br[3:0];
  endfunction

  function automatic logic addr_hit(logic [7:0] a);
    return a == `SF_CTRL1 || a == `SF_CTRL2 || a == `SF_BAUD ||
           a == `SF_STAT || a == `SF_MATCH || a == `SF_DATA;
  endfunction

  function automatic logic [7:0] read_mux(logic [7:0] a, spif_state_t s);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      `SF_CTRL1: r = s.c1;
      `SF_CTRL2: r = s.c2;
      `SF_BAUD:  r = s.br;
      `SF_STAT:  r = {s.rxf, s.mf, s.txe, s.mode_fault_flag, 4'h0};
      `SF_MATCH: r = s.mr;
      `SF_DATA:  r = s.rxb;
      default:   r = 8'h00;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  spif_state_t s_q;
  spif_state_t s_d;
  logic        en;
  logic        mst;
  logic        bidir;
  logic        acc;
  logic        stall;
  logic        din;
  logic        fault;
  logic        edge_ev;
  logic        done_ev;
  logic        copy_ev;
  logic        load_ev;

  assign en    = s_q.c1[`SF_SE];
  assign mst   = s_q.c1[`SF_MS];
  assign bidir = s_q.c2[`SF_BIDIR];
  assign acc   = PSEL & PENABLE;

  // master clock freezes only with stop-in-wait
  assign stall = s_q.c2[`SF_SWAI] & CPU_WAIT;

  assign din = mst ? (bidir ? MOSI_IN : MISO_IN)
                   : (bidir ? MISO_IN : MOSI_IN);

  assign fault = en & mst & s_q.c2[`SF_MFEN] & ~s_q.c1[`SF_SELECT_OUTPUT_ENABLE] & ~SS_N_IN;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d      = s_q;
    edge_ev  = 1'b0;
    done_ev  = 1'b0;
    copy_ev  = 1'b0;
    load_ev  = 1'b0;
    s_d.sck_prev = SCK_IN;

    // Read data and error are captured in the setup phase
    if (PSEL && !PENABLE) begin
      s_d.slverr = ~addr_hit(PADDR);
      s_d.rdata  = read_mux(PADDR, s_q);
    end

    if (acc && PWRITE) begin
      unique case (PADDR)
        // control one, bit 7 down to bit 0
        `SF_CTRL1: begin
          s_d.c1 = PWDATA[7:0];
          if (s_q.arm_fl) begin
            s_d.mode_fault_flag = 1'b0;
          end
          s_d.arm_fl = 1'b0;
        end
        `SF_CTRL2: s_d.c2 = PWDATA[7:0] & `SF_C2_MASK;
        `SF_BAUD:  s_d.br = PWDATA[7:0] & `SF_BR_MASK;
        `SF_MATCH: s_d.mr = PWDATA[7:0];
        `SF_DATA: begin
          if (s_q.txe) begin
            s_d.txb = PWDATA[7:0];
          end
          if (s_q.arm_tx) begin
            s_d.txe = 1'b0;
          end
          s_d.arm_tx = 1'b0;
        end
        default: ;
      endcase
    end

    if (acc && !PWRITE) begin
      if (PADDR == `SF_STAT) begin
        s_d.arm_rx = s_q.rdata[`SF_RXF];
        s_d.arm_mf = s_q.rdata[`SF_MF];
        s_d.arm_tx = s_q.rdata[`SF_TXE];
        s_d.arm_fl = s_q.rdata[`SF_MODE_FAULT_FLAG];
      end
      if (PADDR == `SF_DATA) begin
        // armed read clears receive-full and match
        if (s_q.arm_rx) begin
          s_d.rxf = 1'b0;
        end
        if (s_q.arm_mf) begin
          s_d.mf = 1'b0;
        end
        s_d.arm_rx = 1'b0;
        s_d.arm_mf = 1'b0;
      end
    end

    // Transfer engine; events below win over clears above
    unique case (s_q.mode)
      SF_IDLE: begin
        s_d.sck  = s_q.c1[`SF_CLOCK_POLARITY];
        s_d.ecnt = 5'h00;
        s_d.div  = 20'h0_0000;
        if (en && mst && !s_q.txe && !s_q.mode_fault_flag) begin
          load_ev  = 1'b1;
          s_d.mode = SF_MXFER;
        end else if (en && !mst && !SS_N_IN) begin
          load_ev  = ~s_q.txe;
          s_d.mode = SF_SXFER;
        end
        // buffer moved to shifter, can take a byte
        if (load_ev) begin
          s_d.sh  = s_q.txb;
          s_d.txe = 1'b1;
        end
        s_d.obit = pick_bit(s_d.sh, s_q.c1[`SF_LSBF]);
      end
      SF_MXFER: begin
        if (!stall) begin
          if (s_q.div == half_period(s_q.br) - 20'h0_0001) begin
            s_d.div = 20'h0_0000;
            s_d.sck = ~s_q.sck;
            edge_ev = 1'b1;
          end else begin
            s_d.div = s_q.div + 20'h0_0001;
          end
        end
      end
      SF_SXFER: begin
        if (SS_N_IN) begin
          s_d.mode = SF_IDLE;
        end else begin
          edge_ev = SCK_IN ^ s_q.sck_prev;
        end
      end
      default: s_d.mode = SF_IDLE;
    endcase

    if (edge_ev) begin
      // phase picks sampling or driving edges
      if (s_q.ecnt[0] == s_q.c1[`SF_CLOCK_PHASE]) begin
        s_d.sh = shift_in(s_q.sh, din, s_q.c1[`SF_LSBF]);
      end else begin
        s_d.obit = pick_bit(s_q.sh, s_q.c1[`SF_LSBF]);
      end
      s_d.ecnt = s_q.ecnt + 5'h01;
      if (s_q.ecnt == `SF_LAST_EDGE) begin
        done_ev  = 1'b1;
        s_d.mode = SF_IDLE;
      end
    end

    // a full buffer keeps its byte
    copy_ev = done_ev & ~s_q.rxf;
    if (copy_ev) begin
      s_d.rxb = s_d.sh;
      s_d.rxf = 1'b1;
    end
    if (copy_ev && s_d.sh == s_q.mr) begin
      s_d.mf = 1'b1;
    end

    if (!en) begin
      s_d.mode = SF_IDLE;
    end

    // fault aborts and drops to slave
    if (fault) begin
      s_d.mode_fault_flag      = 1'b1;
      s_d.c1[`SF_MS] = 1'b0;
      s_d.mode      = SF_IDLE;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_q      <= '0;
      s_q.c1   <= `SF_C1_RST;
      s_q.c2   <= `SF_C2_RST;
      s_q.br   <= `SF_BR_RST;
      s_q.mr   <= `SF_MR_RST;
      s_q.txe  <= 1'b1;
      s_q.mode <= SF_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign PRDATA  = {24'h00_0000, s_q.rdata};
  assign PREADY  = 1'b1;
  assign PSLVERR = acc & s_q.slverr;

  // general mask; transmit mask; match mask
  // any enabled flag; fault level; gated by enable
  assign IRQ = en & ((s_q.c1[`SF_RFIE] & (s_q.rxf | s_q.mode_fault_flag)) |
                     (s_q.c1[`SF_TIE] & s_q.txe) |
                     (s_q.c2[`SF_MIE] & s_q.mf));

  assign SCK_OUT  = s_q.sck;
  assign SCK_OE   = en & mst & ~s_q.mode_fault_flag;
  assign MOSI_OUT = s_q.obit;
  assign MISO_OUT = s_q.obit;

  // shared pin is input unless enabled
  assign MOSI_OE = en & mst & ~s_q.mode_fault_flag & (~bidir | s_q.c2[`SF_BDOE]);
  assign MISO_OE = en & ~mst & ~SS_N_IN & ~s_q.mode_fault_flag &
                   (~bidir | s_q.c2[`SF_BDOE]);

  assign SS_N_OUT = s_q.mode != SF_MXFER;
  assign SS_N_OE  = en & mst & s_q.c2[`SF_MFEN] & s_q.c1[`SF_SELECT_OUTPUT_ENABLE];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);

  gen_mask_a: assert property (
    IRQ && !(s_q.c1[`SF_TIE] && s_q.txe) && !(s_q.c2[`SF_MIE] && s_q.mf)
      |-> s_q.c1[`SF_RFIE] && (s_q.rxf || s_q.mode_fault_flag))
    else $error("irq without enabled receive or fault source");

  tx_mask_a: assert property (
    en && s_q.c1[`SF_TIE] && s_q.txe |-> IRQ)
    else $error("transmit-empty irq missing");

  match_mask_a: assert property (
    IRQ && !s_q.c1[`SF_RFIE] && !s_q.c1[`SF_TIE] |-> s_q.c2[`SF_MIE] && s_q.mf)
    else $error("irq without enabled match source");

  any_flag_a: assert property (
    en && s_q.c1[`SF_RFIE] && s_q.rxf |-> IRQ)
    else $error("receive-full irq missing");

  poll_set_a: assert property (
    copy_ev && !s_q.c1[`SF_RFIE] |=> s_q.rxf)
    else $error("flag not set while masked");

  fault_abort_a: assert property (
    fault |=> s_q.mode_fault_flag && !mst && s_q.mode == SF_IDLE ##1 !SCK_OE)
    else $error("mode fault did not abort");

  fault_irq_a: assert property (
    en && s_q.c1[`SF_RFIE] && !s_q.rxf && !(s_q.c1[`SF_TIE] && s_q.txe) && !(s_q.c2[`SF_MIE] && s_q.mf)
      |-> IRQ == s_q.mode_fault_flag)
    else $error("fault irq does not follow flag");

  rx_copy_a: assert property (
    copy_ev |=> s_q.rxf && s_q.rxb == $past(s_d.sh))
    else $error("received byte not copied");

  overrun_a: assert property (
    done_ev && s_q.rxf |=> $stable(s_q.rxb))
    else $error("overrun byte overwrote buffer");

  tx_load_a: assert property (
    load_ev && !fault |=> s_q.txe && s_q.mode != SF_IDLE)
    else $error("transmit-empty not set on load");

  match_set_a: assert property (
    copy_ev && s_d.sh == s_q.mr |=> s_q.mf)
    else $error("match flag not set");

  no_enable_a: assert property (
    !en |-> !IRQ && !SCK_OE && !MOSI_OE && !MISO_OE)
    else $error("activity while port disabled");

endmodule

// ---- bench/spif_slave_model.sv ----
// Remote serial slave exchanging one byte per selection, idle-low clock, either phase
module spif_slave_model (
  // Frame phase
  input  wire logic       clock_phase,
  // Serial pins
  input  wire logic       sck,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  output logic            miso,
  // Bytes exchanged
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh;
  initial begin
    sh = 8'h00;
    miso = 1'b0;
    rx_byte = 8'h00;
  end
  // ----------------------------------------
  // Shifting
  // ----------------------------------------
  always @(negedge ss_n) begin
    sh = tx_byte;
    miso = tx_byte[7];
  end
  // Released line shows the last bit inverted
  always @(posedge ss_n) begin
    miso = ~miso;
  end
  always @(posedge sck) begin
    if (!ss_n) begin
      if (clock_phase) begin
        miso = sh[7];
        sh = {sh[6:0], 1'b0};
      end else begin
        rx_byte = {rx_byte[6:0], mosi};
      end
    end
  end
  // Last sample edge meets deselect, so phase one samples ungated
  always @(negedge sck) begin
    if (clock_phase) begin
      rx_byte = {rx_byte[6:0], mosi};
    end else if (!ss_n) begin
      sh = {sh[6:0], 1'b0};
      miso = sh[7];
    end
  end
endmodule

// ---- bench/spif_core_test.sv ----
// Register-level tests of the serial port flags and interrupt
`include "spif_regs.svh"
module spif_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, psel, pen, pwr, ss_n_in, pready, pslverr, irq, miso, ss_n_out, err;
  logic [7:0] paddr, slv_tx, slv_rx, rd;
  logic cpu_wait, clock_phase;
  logic [3:0] oe;
  logic [31:0] pwdata, prdata;
  wire sck, mosi;
  int bad_count, n_tests, cyc;

  spif_core uut (.REF_CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CPU_WAIT(cpu_wait), .IRQ(irq), .SCK_IN(sck), .SCK_OUT(sck), .SCK_OE(oe[3]), .MOSI_IN(mosi),
    .MOSI_OUT(mosi), .MOSI_OE(oe[2]), .MISO_IN(miso), .MISO_OUT(), .MISO_OE(oe[1]), .SS_N_IN(ss_n_in),
    .SS_N_OUT(ss_n_out), .SS_N_OE(oe[0]));
  spif_slave_model partner (.clock_phase(clock_phase), .sck(sck), .ss_n(ss_n_out), .mosi(mosi), .miso(miso),
    .tx_byte(slv_tx), .rx_byte(slv_rx));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict;
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask
  task irq_chk(input logic exp);
    @(negedge clk);
    chk({7'h00, irq}, {7'h00, exp});
  endtask
  task oe_chk(input logic [3:0] exp);
    @(negedge clk);
    chk({4'h0, oe}, {4'h0, exp});
  endtask
  task xfer(input logic [7:0] tx, input logic [7:0] rx);
    int i;
    slv_tx = rx;
    i = 0;
    apb(1'b0, `SF_STAT, 8'h00);
    wr(`SF_DATA, tx);
    while (ss_n_out !== 1'b0 && i < 50) begin
      @(posedge clk);
      i++;
    end
    chk({7'h00, ss_n_out}, 8'h00);
    while (ss_n_out !== 1'b1 && i < 200) begin
      @(posedge clk);
      i++;
    end
    chk({7'h00, ss_n_out}, 8'h01);
    repeat (3) @(posedge clk);
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {psel, pen, pwr, rst_n} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ss_n_in = 1'b1;
    slv_tx = 8'h00;
    cpu_wait = 1'b0;
    clock_phase = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(`SF_CTRL1, 8'h04);
    rd_chk(`SF_CTRL2, 8'h00);
    rd_chk(`SF_BAUD, 8'h00);
    rd_chk(`SF_STAT, 8'h20);
    rd_chk(`SF_MATCH, 8'h00);
    rd_chk(`SF_DATA, 8'h00);
    rd_chk(8'h18, 8'h00);
    chk({7'h00, err}, 8'h01);
    wr(`SF_CTRL2, 8'hFF);
    rd_chk(`SF_CTRL2, 8'h9B);
    wr(`SF_BAUD, 8'hFF);
    rd_chk(`SF_BAUD, 8'h7F);
    wr(`SF_STAT, 8'h00);
    rd_chk(`SF_STAT, 8'h20);
    $display("registers test done");
    wr(`SF_CTRL1, 8'h50);
    wr(`SF_CTRL2, 8'h00);
    wr(`SF_BAUD, 8'h00);
    wr(`SF_MATCH, 8'hA5);
    rd_chk(`SF_MATCH, 8'hA5);
    oe_chk(4'hC);
    wr(`SF_CTRL2, 8'h01);
    oe_chk(4'h8);
    wr(`SF_CTRL2, 8'h09);
    oe_chk(4'hC);
    wr(`SF_CTRL2, 8'h00);
    xfer(8'h3C, 8'hA5);
    chk(slv_rx, 8'h3C);
    rd_chk(`SF_STAT, 8'hE0);
    irq_chk(1'b0);
    wr(`SF_CTRL2, 8'h80);
    irq_chk(1'b1);
    wr(`SF_CTRL2, 8'h00);
    wr(`SF_CTRL1, 8'h70);
    irq_chk(1'b1);
    wr(`SF_CTRL1, 8'hD0);
    irq_chk(1'b1);
    wr(`SF_CTRL1, 8'hB0);
    irq_chk(1'b0);
    wr(`SF_CTRL1, 8'h50);
    cpu_wait <= 1'b1;
    xfer(8'h0F, 8'h11);
    chk(slv_rx, 8'h0F);
    cpu_wait <= 1'b0;
    rd_chk(`SF_STAT, 8'hE0);
    rd_chk(`SF_DATA, 8'hA5);
    rd_chk(`SF_STAT, 8'h20);
    wr(`SF_CTRL1, 8'hD0);
    irq_chk(1'b0);
    wr(`SF_CTRL1, 8'h54);
    clock_phase <= 1'b1;
    xfer(8'hC3, 8'h5A);
    chk(slv_rx, 8'hC3);
    rd_chk(`SF_STAT, 8'hA0);
    rd_chk(`SF_DATA, 8'h5A);
    clock_phase <= 1'b0;
    wr(`SF_CTRL1, 8'hD0);
    $display("transfer test done");
    wr(`SF_CTRL2, 8'h10);
    wr(`SF_CTRL1, 8'hD2);
    oe_chk(4'hD);
    wr(`SF_CTRL1, 8'hD0);
    @(posedge clk);
    ss_n_in <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk(`SF_STAT, 8'h30);
    irq_chk(1'b1);
    rd_chk(`SF_CTRL1, 8'hC0);
    oe_chk(4'h0);
    @(posedge clk);
    ss_n_in <= 1'b1;
    irq_chk(1'b1);
    wr(`SF_CTRL1, 8'hC0);
    rd_chk(`SF_STAT, 8'h20);
    irq_chk(1'b0);
    $display("mode fault test done");
    give_verdict;
  end
endmodule
